// file: common/dac_override_regs.svh
// register offsets, field positions, reset values and timing figures
// of the dac result and substitute register bank.
// assumes: included by bare name; holds definitions only.
`ifndef DAC_OVERRIDE_REGS_SVH
`define DAC_OVERRIDE_REGS_SVH

// ---------------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------------
`define ADDR_TEMP_HIGH       8'h00
`define ADDR_TEMP_LOW        8'h01
`define ADDR_CHAN0_HIGH      8'h02
`define ADDR_CHAN0_LOW       8'h03
`define ADDR_CHAN1_HIGH      8'h04
`define ADDR_CHAN1_LOW       8'h05
`define ADDR_SENSOR_STATUS   8'h07
`define ADDR_SUB_CONTROL     8'h08
`define ADDR_TEMP_SUB_HIGH   8'h09
`define ADDR_TEMP_SUB_LOW    8'h0A
`define ADDR_CHAN0_SUB_HIGH  8'h0B
`define ADDR_CHAN0_SUB_LOW   8'h0C
`define ADDR_CHAN1_SUB_HIGH  8'h0D
`define ADDR_CHAN1_SUB_LOW   8'h0E

// ---------------------------------------------------------------------
// fields and reset values
// ---------------------------------------------------------------------
`define CTRL_TEMP_BIT        0
`define CTRL_DAC_BIT         1
`define CTRL_RESET           2'h0
`define CTRL_PAD             6'h00
`define UPPER_ZERO           4'h0
`define BYTE_ZERO            8'h00
`define WORD_RESET           12'h000
`define NIBBLE_RESET         4'h0
`define STATUS_NOT_READY     8'h01
`define STATUS_READY         8'h00
`define SLOT_NONE            2'h3

// ---------------------------------------------------------------------
// timing
// ---------------------------------------------------------------------
`define REF_CLK_HZ           50_000_000
`define MS_PER_S             1000
`define READY_TIMEOUT_MS     100

`endif

// file: common/dac_override_pkg.sv
// state types of the dac result and substitute register bank.
// assumes: compiled before every design file; never imported.
package dac_override_pkg;

  typedef logic [11:0] word_t;

  // one split substitute word: pending nibble and committed word
  typedef struct packed {
    logic [3:0] pendHigh;
    word_t      word;
  } sub_word_s;

  // state of the register bank, except the substitute words held in override_word
  typedef struct packed {
    word_t       tempWord;
    word_t       result0;
    word_t       result1;
    logic [7:0]  shadowTempLow;
    word_t       shadow0;
    word_t       shadow1;
    logic        seqActive;
    logic [1:0]  pairHeld;
    logic [1:0]  control;
    logic        notReady;
    logic [31:0] readyCount;
    logic [7:0]  rdData;
    word_t       lutIndex;
    word_t       dacInput0;
    word_t       dacInput1;
  } bank_state_s;

endpackage : dac_override_pkg

// file: hdl/override_word.sv
// one 12-bit substitute word split over a nibble and a byte register.
// assumes: write strobes are one-cycle pulses on ref_clk, never both
// high in one cycle.
`timescale 1ns/100ps
`include "dac_override_regs.svh"

module override_word (
  input  wire logic                     ref_clk,
  input  wire logic                     nrst,
  input  wire logic                     wrHigh,
  input  wire logic                     wrLow,
  input  wire logic [7:0]               wrData,
  output      dac_override_pkg::word_t  word
);

  dac_override_pkg::sub_word_s state_reg;
  dac_override_pkg::sub_word_s state_next;

  // high nibble waits; the low byte commits both halves at once, so
  // the consumer never sees half an update
  always_comb
  begin
    state_next = state_reg;
    if (wrHigh)
    begin
      state_next.pendHigh = wrData[3:0];
    end
    if (wrLow)
    begin
      state_next.word = {state_reg.pendHigh, wrData};
    end
  end

  // volatile: cleared at power-up
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_reg.pendHigh <= `NIBBLE_RESET;
      state_reg.word     <= `WORD_RESET;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign word = state_reg.word;

endmodule : override_word

// file: hdl/dac_data_override_regs.sv
// dac result, sensor status and substitute register bank.
// assumes: the serial slave engine outside hands over byte accesses as
// one-cycle strobes on ref_clk; sensor, lookup and alu logic run on
// ref_clk too, so no input here needs a synchroniser. privilege comes
// from the access gate register, which lives outside.
//
// Behaviour
// - alu result per channel is stored and drives its dac unless overridden.
// - temp high, temp low, chan0, chan1 read in order return one sample.
// - sequence stays coherent when the temp low read is skipped.
// - 0x02 gives chan0 upper nibble in 3:0, 0x03 lower byte; read only.
// - 0x04 gives chan1 upper nibble in 3:0, 0x05 lower byte; read only.
// - status 0x07 reads nonzero after power-up, zero within 100 ms.
// - control bit 0 indexes lookup with temperature substitute word.
// - control bit 1 feeds both dacs from substitute words together.
// - upper nibble waits; lower byte write commits the whole word.
// - 0x09 temperature substitute nibble, 0x0A low byte; privileged rw.
// - 0x0B chan0 substitute nibble, 0x0C low byte; privileged rw.
// - 0x0D chan1 substitute nibble, 0x0E low byte; privileged rw.
// - control and substitute registers are volatile, zero at power-up.
// - temp high read freezes temp low for the following read.
// - substitute and control writes need the privileged access level.
`timescale 1ns/100ps
`include "dac_override_regs.svh"

module dac_data_override_regs #(
  parameter int unsigned READY_CYCLES =
    `READY_TIMEOUT_MS * (`REF_CLK_HZ / `MS_PER_S)
) (
  input  wire logic                     ref_clk,
  input  wire logic                     nrst,
  input  wire logic [7:0]               regAddr,
  input  wire logic [7:0]               regWrData,
  input  wire logic                     regWrite,
  input  wire logic                     regRead,
  output      logic [7:0]               regRdData,
  input  wire logic                     privilegedAccess,
  input  wire dac_override_pkg::word_t  sensorTemp,
  input  wire logic                     sensorValid,
  input  wire dac_override_pkg::word_t  aluResult0,
  input  wire dac_override_pkg::word_t  aluResult1,
  input  wire logic                     aluValid,
  output      dac_override_pkg::word_t  lutIndex,
  output      dac_override_pkg::word_t  dacInput0,
  output      dac_override_pkg::word_t  dacInput1,
  output      logic                     tempOverrideOn,
  output      logic                     dacOverrideOn,
  output      logic                     sensorReady
);

  // ---------------------------------------------------------------------
  // constants and helpers
  // ---------------------------------------------------------------------
  // a timeout of zero cycles makes no sense; one cycle is the floor
  localparam logic [31:0] READY_LAST =
    (READY_CYCLES > 1) ? 32'(READY_CYCLES - 1) : 32'h0000_0000;
  localparam int          SUB_COUNT  = 3;

  // upper nibble of a word, reserved bits 7:4 read as zero
  function automatic logic [7:0] highByte(
    input dac_override_pkg::word_t w
  );
    highByte = {`UPPER_ZERO, w[11:8]};
  endfunction : highByte

  // lower byte of a word, passed through unchanged
  function automatic logic [7:0] lowByte(
    input dac_override_pkg::word_t w
  );
    lowByte = w[7:0];
  endfunction : lowByte

  // which substitute word an address selects; SLOT_NONE if none
  function automatic logic [1:0] subSlot(input logic [7:0] addr);
    case (addr)
      `ADDR_TEMP_SUB_HIGH, `ADDR_TEMP_SUB_LOW:   subSlot = 2'h0;
      `ADDR_CHAN0_SUB_HIGH, `ADDR_CHAN0_SUB_LOW: subSlot = 2'h1;
      `ADDR_CHAN1_SUB_HIGH, `ADDR_CHAN1_SUB_LOW: subSlot = 2'h2;
      default:                                   subSlot = `SLOT_NONE;
    endcase
  endfunction : subSlot

  // true for the byte half of any substitute pair
  function automatic logic subIsLow(input logic [7:0] addr);
    subIsLow = (addr == `ADDR_TEMP_SUB_LOW)
            || (addr == `ADDR_CHAN0_SUB_LOW)
            || (addr == `ADDR_CHAN1_SUB_LOW);
  endfunction : subIsLow

  // ---------------------------------------------------------------------
  // write decode
  // ---------------------------------------------------------------------
  dac_override_pkg::bank_state_s state_reg;
  dac_override_pkg::bank_state_s state_next;
  dac_override_pkg::word_t       subWord [SUB_COUNT];
  logic                          wrAllowed;
  logic                          ctrlWrite;
  logic [SUB_COUNT-1:0]          subWrHigh;
  logic [SUB_COUNT-1:0]          subWrLow;
  logic [1:0]                    rdSlot;

  // writes below privilege vanish without trace; read-only addresses
  // decode to nothing, so a write there touches no state
  assign wrAllowed = regWrite && privilegedAccess;
  assign ctrlWrite = wrAllowed && (regAddr == `ADDR_SUB_CONTROL);
  // the read side decodes the slot map once per cycle
  assign rdSlot    = subSlot(regAddr);

  // ---------------------------------------------------------------------
  // substitute words
  // ---------------------------------------------------------------------
  for (genvar i = 0; i < SUB_COUNT; i++)
  begin : g_sub
    // slots 0, 1, 2: temperature, chan0, chan1
    assign subWrHigh[i] = wrAllowed && (subSlot(regAddr) == 2'(i))
                          && !subIsLow(regAddr);
    assign subWrLow[i]  = wrAllowed && (subSlot(regAddr) == 2'(i))
                          && subIsLow(regAddr);

    // each slot keeps its own pending nibble
    override_word u_word (
      .ref_clk (ref_clk),
      .nrst    (nrst),
      .wrHigh  (subWrHigh[i]),
      .wrLow   (subWrLow[i]),
      .wrData  (regWrData),
      .word    (subWord[i])
    );
  end

  // ---------------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------------
  // sample capture, ready timer, control, read mux with shadowing, and
  // the data-path multiplexers all in one place
  always_comb
  begin
    state_next = state_reg;

    // sensor and alu samples; a fresh sample also proves the sensor up
    if (sensorValid)
    begin
      state_next.tempWord = sensorTemp;
      state_next.notReady = 1'b0;
    end
    // the timer halts at its limit, so a long wait never wraps it
    else if (state_reg.notReady)
    begin
      if (state_reg.readyCount >= READY_LAST)
      begin
        state_next.notReady = 1'b0;
      end
      else
      begin
        state_next.readyCount = state_reg.readyCount + 32'h0000_0001;
      end
    end

    // both results are taken in one edge, never one channel alone
    if (aluValid)
    begin
      state_next.result0 = aluResult0;
      state_next.result1 = aluResult1;
    end

    // only the two defined bits are stored; reserved bits read zero
    // 0x3 is not refused: both muxes switch, the host must avoid it
    if (ctrlWrite)
    begin
      state_next.control = regWrData[1:0];
    end

    // read mux; the answer lands in rdData at the next edge
    // reads need no privilege and never touch the substitute words
    if (regRead)
    begin
      // a lone pair snapshot serves the very next read only
      state_next.pairHeld = 2'b00;
      case (regAddr)
        `ADDR_TEMP_HIGH:
        begin
          // freeze the rest of the sequence from this very sample
          state_next.rdData        = highByte(state_reg.tempWord);
          state_next.shadowTempLow = lowByte(state_reg.tempWord);
          state_next.shadow0       = state_reg.result0;
          state_next.shadow1       = state_reg.result1;
          state_next.seqActive     = 1'b1;
        end

        // outside a sequence the live low byte is returned
        `ADDR_TEMP_LOW:
        begin
          state_next.rdData = state_reg.seqActive
                            ? state_reg.shadowTempLow
                            : lowByte(state_reg.tempWord);
        end

        `ADDR_CHAN0_HIGH:
        begin
          // outside a sequence the pair alone is kept coherent
          if (state_reg.seqActive)
          begin
            state_next.rdData = highByte(state_reg.shadow0);
          end
          else
          begin
            state_next.rdData   = highByte(state_reg.result0);
            state_next.shadow0  = state_reg.result0;
            state_next.pairHeld = 2'b01;
          end
        end

        // the low byte pairs with whichever snapshot is live
        `ADDR_CHAN0_LOW:
        begin
          state_next.rdData =
            (state_reg.seqActive || state_reg.pairHeld[0])
            ? lowByte(state_reg.shadow0)
            : lowByte(state_reg.result0);
        end

        // same scheme as channel 0
        `ADDR_CHAN1_HIGH:
        begin
          if (state_reg.seqActive)
          begin
            state_next.rdData = highByte(state_reg.shadow1);
          end
          else
          begin
            state_next.rdData   = highByte(state_reg.result1);
            state_next.shadow1  = state_reg.result1;
            state_next.pairHeld = 2'b10;
          end
        end

        `ADDR_CHAN1_LOW:
        begin
          // last register of the sequence closes it
          state_next.rdData =
            (state_reg.seqActive || state_reg.pairHeld[1])
            ? lowByte(state_reg.shadow1)
            : lowByte(state_reg.result1);
          state_next.seqActive = 1'b0;
        end

        // any read past the sequence ends it, so a stale
        // snapshot never answers a later unrelated read
        `ADDR_SENSOR_STATUS:
        begin
          state_next.rdData    = state_reg.notReady
                               ? `STATUS_NOT_READY
                               : `STATUS_READY;
          state_next.seqActive = 1'b0;
        end

        `ADDR_SUB_CONTROL:
        begin
          state_next.rdData    = {`CTRL_PAD, state_reg.control};
          state_next.seqActive = 1'b0;
        end

        default:
        begin
          // substitute words read back committed values; gaps read zero
          state_next.seqActive = 1'b0;
          if (rdSlot == `SLOT_NONE)
          begin
            state_next.rdData = `BYTE_ZERO;
          end
          else if (subIsLow(regAddr))
          begin
            state_next.rdData = lowByte(subWord[rdSlot]);
          end
          else
          begin
            state_next.rdData = highByte(subWord[rdSlot]);
          end
        end
      endcase
    end

    // data-path multiplexers; each output follows its source by one edge
    // registered, so a dac never sees a glitch from the decode above
    state_next.lutIndex  = state_reg.control[`CTRL_TEMP_BIT]
                         ? subWord[0]
                         : state_reg.tempWord;

    state_next.dacInput0 = state_reg.control[`CTRL_DAC_BIT]
                         ? subWord[1]
                         : state_reg.result0;

    state_next.dacInput1 = state_reg.control[`CTRL_DAC_BIT]
                         ? subWord[2]
                         : state_reg.result1;
  end

  // ---------------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------------
  // power-up clears every volatile field; status starts at not ready
  // shadows clear too, so no snapshot outlives a reset
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_reg.tempWord      <= `WORD_RESET;
      state_reg.result0       <= `WORD_RESET;
      state_reg.result1       <= `WORD_RESET;
      state_reg.shadowTempLow <= `BYTE_ZERO;
      state_reg.shadow0       <= `WORD_RESET;
      state_reg.shadow1       <= `WORD_RESET;
      state_reg.seqActive     <= 1'b0;
      state_reg.pairHeld      <= 2'b00;
      state_reg.control       <= `CTRL_RESET;
      state_reg.notReady      <= 1'b1;
      state_reg.readyCount    <= 32'h0000_0000;
      state_reg.rdData        <= `BYTE_ZERO;
      state_reg.lutIndex      <= `WORD_RESET;
      state_reg.dacInput0     <= `WORD_RESET;
      state_reg.dacInput1     <= `WORD_RESET;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // ---------------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------------
  // every output comes straight from a flop of the state register, except sensorReady, which inverts notReady
  assign regRdData      = state_reg.rdData;
  assign lutIndex       = state_reg.lutIndex;
  assign dacInput0      = state_reg.dacInput0;
  assign dacInput1      = state_reg.dacInput1;
  assign tempOverrideOn = state_reg.control[`CTRL_TEMP_BIT];
  assign dacOverrideOn  = state_reg.control[`CTRL_DAC_BIT];
  assign sensorReady    = !state_reg.notReady;

endmodule : dac_data_override_regs

// file: tb/dac_data_override_regs_properties.sv
// port-level checks of the dac result and substitute register bank.
// assumes: bound into dac_data_override_regs; one clock, async reset.
`timescale 1ns/100ps

module dac_data_override_regs_properties #(
  parameter int unsigned READY_CYCLES = 20
) (
  input wire logic                    ref_clk,
  input wire logic                    nrst,
  input wire logic [7:0]              regAddr,
  input wire logic [7:0]              regWrData,
  input wire logic                    regWrite,
  input wire logic                    regRead,
  input wire logic [7:0]              regRdData,
  input wire logic                    privilegedAccess,
  input wire logic                    aluValid,
  input wire dac_override_pkg::word_t aluResult0,
  input wire dac_override_pkg::word_t dacInput0,
  input wire logic                    tempOverrideOn,
  input wire logic                    dacOverrideOn,
  input wire logic                    sensorReady
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  // cycles spent not ready since reset; bounds the ready wait
  logic [31:0] waitCnt_reg;
  always_ff @(posedge ref_clk or negedge nrst)
    if (!nrst) waitCnt_reg <= 32'h0000_0000;
    else if (!sensorReady) waitCnt_reg <= waitCnt_reg + 32'h0000_0001;

  sequence s_ctlWr;
    regWrite && regAddr == 8'h08 && privilegedAccess;
  endsequence
  // nibble then byte of channel 0 while the substitute path is live
  sequence s_subPair;
    regWrite && regAddr == 8'h0B && privilegedAccess ##1
    regWrite && regAddr == 8'h0C && privilegedAccess && dacOverrideOn ##1
    dacOverrideOn;
  endsequence

  a_temp_enable_follows: assert property (s_ctlWr |=>
    tempOverrideOn == $past(regWrData[0])) else $error("temp enable wrong");
  a_dac_enable_follows: assert property (s_ctlWr |=>
    dacOverrideOn == $past(regWrData[1])) else $error("dac enable wrong");
  a_ctl_locked_out: assert property (
    regWrite && regAddr == 8'h08 && !privilegedAccess |=>
    $stable(tempOverrideOn) && $stable(dacOverrideOn))
    else $error("control changed without privilege");
  a_dac_from_alu: assert property (
    aluValid ##1 (!aluValid && !dacOverrideOn) |=>
    dacInput0 == $past(aluResult0, 2)) else $error("dac not from result");
  a_sub_pair_commit: assert property (s_subPair |=>
    dacInput0 == {$past(regWrData[3:0], 3), $past(regWrData, 2)})
    else $error("substitute word not applied");
  a_high_waits: assert property (
    regWrite && regAddr == 8'h0B && privilegedAccess && dacOverrideOn ##1
    (!(regWrite && regAddr == 8'h0C) && dacOverrideOn) |=>
    $stable(dacInput0)) else $error("nibble applied before byte");
  a_unmapped_zero: assert property (
    regRead && regAddr inside {8'h06, [8'h0F:8'hFF]} |=>
    regRdData == 8'h00) else $error("unmapped read not zero");
  a_ctl_readback: assert property (regRead && regAddr == 8'h08 |=>
    regRdData == {6'h00, dacOverrideOn, tempOverrideOn})
    else $error("control readback wrong");
  a_status_code: assert property (regRead && regAddr == 8'h07 |=>
    regRdData == ($past(sensorReady) ? 8'h00 : 8'h01))
    else $error("status code wrong");
  a_nibble_pad: assert property (
    regRead && regAddr inside {8'h00, 8'h02, 8'h04, 8'h09, 8'h0B, 8'h0D}
    |=> regRdData[7:4] == 4'h0) else $error("upper bits not zero");
  a_ready_in_time: assert property (
    waitCnt_reg <= READY_CYCLES + 4) else $error("sensor ready too late");
endmodule : dac_data_override_regs_properties

bind dac_data_override_regs dac_data_override_regs_properties #(
  .READY_CYCLES(READY_CYCLES)
) chk (
  .ref_clk(ref_clk), .nrst(nrst), .regAddr(regAddr),
  .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
  .regRdData(regRdData), .privilegedAccess(privilegedAccess),
  .aluValid(aluValid), .aluResult0(aluResult0), .dacInput0(dacInput0),
  .tempOverrideOn(tempOverrideOn), .dacOverrideOn(dacOverrideOn),
  .sensorReady(sensorReady)
);

// file: tb/reg_host_model.sv
// host stand-in: single-byte register accesses and privilege level.
// assumes: tasks are entered at a rising edge of ref_clk.
`timescale 1ns/100ps

module reg_host_model (
  input  wire logic       ref_clk,
  input  wire logic [7:0] regRdData,
  output      logic [7:0] regAddr,
  output      logic [7:0] regWrData,
  output      logic       regWrite,
  output      logic       regRead,
  output      logic       privilegedAccess
);
  // power up idle and locked out of the privileged level
  initial
  begin
    regAddr = 8'h00;
    regWrData = 8'h00;
    regWrite = 1'b0;
    regRead = 1'b0;
    privilegedAccess = 1'b0;
  end

  // strobe is left up so that writes can follow back to back
  task wrReg(input logic [7:0] a, input logic [7:0] d);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    regRead <= 1'b0;
    @(posedge ref_clk);
  endtask : wrReg

  // answer is taken one edge after the read was accepted
  task rdReg(input logic [7:0] a, output logic [7:0] d);
    regAddr <= a;
    regRead <= 1'b1;
    regWrite <= 1'b0;
    @(posedge ref_clk);
    regRead <= 1'b0;
    regAddr <= ~a;
    @(posedge ref_clk);
    d = regRdData;
  endtask : rdReg

  // only the codes 0, 1 and 2 are sent, reserved bits always zero
  task setCtl(input logic [1:0] v);
    wrReg(8'h08, {6'h00, v});
  endtask : setCtl

  // level the access gate would give after the password sequence
  task unlock(input logic on);
    privilegedAccess <= on;
    @(posedge ref_clk);
  endtask : unlock

  // released lines flip so a stale value is never mistaken for data
  task idle(input int n);
    repeat (n)
    begin
      regWrite <= 1'b0;
      regRead <= 1'b0;
      regAddr <= ~regAddr;
      regWrData <= ~regWrData;
      @(posedge ref_clk);
    end
  endtask : idle
endmodule : reg_host_model

// file: tb/dac_data_override_regs_tb.sv
// self-checking bench of the dac result and substitute register bank.
// assumes: reg_host_model stands in for the serial slave engine.
`timescale 1ns/100ps

module dac_data_override_regs_tb;
  localparam int unsigned READY = 20;
  logic ref_clk, nrst, regWrite, regRead, privilegedAccess;
  logic sensorValid, aluValid, tempOverrideOn, dacOverrideOn, sensorReady;
  logic [7:0] regAddr, regWrData, regRdData, rdVal;
  dac_override_pkg::word_t sensorTemp, aluResult0, aluResult1;
  dac_override_pkg::word_t lutIndex, dacInput0, dacInput1;
  int miscompares = 0;
  int checked = 0;

  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  dac_data_override_regs #(.READY_CYCLES(READY)) DUT (
    .ref_clk(ref_clk), .nrst(nrst), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
    .regRdData(regRdData), .privilegedAccess(privilegedAccess),
    .sensorTemp(sensorTemp), .sensorValid(sensorValid),
    .aluResult0(aluResult0), .aluResult1(aluResult1), .aluValid(aluValid),
    .lutIndex(lutIndex), .dacInput0(dacInput0), .dacInput1(dacInput1),
    .tempOverrideOn(tempOverrideOn), .dacOverrideOn(dacOverrideOn),
    .sensorReady(sensorReady));

  reg_host_model host (
    .ref_clk(ref_clk), .regRdData(regRdData), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
    .privilegedAccess(privilegedAccess));

  task chk(input string what, input logic [11:0] e, input logic [11:0] g);
    checked++;
    if (g !== e)
    begin
      $display("[FAIL] %s expected %h seen %h", what, e, g);
      miscompares++;
    end
  endtask : chk

  task rdChk(input logic [7:0] a, input logic [11:0] e);
    host.rdReg(a, rdVal);
    chk($sformatf("register %h", a), e, {4'h0, rdVal});
  endtask : rdChk

  task wrap_up;
    if (miscompares == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : wrap_up

  task doReset;
    nrst <= 1'b0;
    repeat (16) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
  endtask : doReset

  // one sensor and result sample; lines flip once the pulse is over
  task push(input logic [11:0] t, input logic [11:0] a0,
            input logic [11:0] a1);
    sensorTemp <= t;
    aluResult0 <= a0;
    aluResult1 <= a1;
    sensorValid <= 1'b1;
    aluValid <= 1'b1;
    @(posedge ref_clk);
    sensorValid <= 1'b0;
    aluValid <= 1'b0;
    sensorTemp <= ~t;
    aluResult0 <= ~a0;
    aluResult1 <= ~a1;
    @(posedge ref_clk);
  endtask : push

  // -------------------------------------------------------------------
  // scenarios
  // -------------------------------------------------------------------
  task t_reset_values;
    rdChk(8'h07, 12'h001);
    chk("sensorReady", 12'h000, {11'h000, sensorReady});
    for (int a = 8; a <= 14; a++) rdChk(8'(a), 12'h000);
    chk("dacInput0", 12'h000, dacInput0);
  endtask : t_reset_values

  // sensor moves between the first and later reads of the sequence
  task t_coherent(input bit skipLow);
    push(12'hABC, 12'h123, 12'h456);
    host.idle(2);
    chk("dacInput0", 12'h123, dacInput0);
    chk("dacInput1", 12'h456, dacInput1);
    chk("lutIndex", 12'hABC, lutIndex);
    rdChk(8'h00, 12'h00A);
    push(12'h321, 12'h654, 12'h987);
    if (!skipLow) rdChk(8'h01, 12'h0BC);
    rdChk(8'h02, 12'h001);
    rdChk(8'h03, 12'h023);
    rdChk(8'h04, 12'h004);
    rdChk(8'h05, 12'h056);
    rdChk(8'h07, 12'h000);
  endtask : t_coherent

  task t_read_only;
    host.unlock(1'b1);
    host.wrReg(8'h02, 8'hFF);
    host.wrReg(8'h07, 8'h5A);
    rdChk(8'h02, 12'h006);
    rdChk(8'h03, 12'h054);
    rdChk(8'h07, 12'h000);
    rdChk(8'h06, 12'h000);
    rdChk(8'h20, 12'h000);
  endtask : t_read_only

  task t_dac_sub;
    host.wrReg(8'h0B, 8'h08);
    rdChk(8'h0B, 12'h000);
    host.wrReg(8'h0C, 8'h00);
    host.wrReg(8'h0D, 8'h04);
    host.wrReg(8'h0E, 8'h00);
    rdChk(8'h0B, 12'h008);
    host.setCtl(2'h2);
    host.idle(2);
    chk("dacInput0", 12'h800, dacInput0);
    chk("dacInput1", 12'h400, dacInput1);
    push(12'hFFF, 12'hEEE, 12'hDDD);
    host.idle(2);
    chk("dacInput1", 12'h400, dacInput1);
    rdChk(8'h02, 12'h00E);
    host.wrReg(8'h0B, 8'h0A);
    host.wrReg(8'h0C, 8'h5A);
    host.idle(2);
    chk("dacInput0", 12'hA5A, dacInput0);
    host.wrReg(8'h0B, 8'h03);
    rdChk(8'h0B, 12'h00A);
    chk("dacInput0", 12'hA5A, dacInput0);
    host.setCtl(2'h0);
    host.idle(2);
    chk("dacInput0", 12'hEEE, dacInput0);
  endtask : t_dac_sub

  task t_temp_sub;
    host.wrReg(8'h09, 8'h05);
    host.wrReg(8'h0A, 8'h67);
    host.setCtl(2'h1);
    host.idle(2);
    chk("lutIndex", 12'h567, lutIndex);
    rdChk(8'h0A, 12'h067);
    rdChk(8'h08, 12'h001);
    host.setCtl(2'h0);
    host.idle(2);
    chk("lutIndex", 12'hFFF, lutIndex);
  endtask : t_temp_sub

  task t_locked;
    host.unlock(1'b0);
    host.wrReg(8'h08, 8'h02);
    host.wrReg(8'h0E, 8'hFF);
    rdChk(8'h08, 12'h000);
    rdChk(8'h0E, 12'h000);
  endtask : t_locked

  // second reset in mid-run: volatile state clears, ready comes in time
  task t_ready_time;
    int n;
    doReset();
    rdChk(8'h0B, 12'h000);
    for (n = 0; n < READY + 8 && sensorReady !== 1'b1; n++)
      @(posedge ref_clk);
    chk("sensorReady", 12'h001, {11'h000, sensorReady});
    if (sensorReady !== 1'b1) wrap_up();
    rdChk(8'h07, 12'h000);
  endtask : t_ready_time

  initial
  begin
    sensorTemp = 12'h000;
    aluResult0 = 12'h000;
    aluResult1 = 12'h000;
    sensorValid = 1'b0;
    aluValid = 1'b0;
    doReset();
    t_reset_values();
    t_coherent(1'b0);
    t_coherent(1'b1);
    t_read_only();
    t_dac_sub();
    t_temp_sub();
    t_locked();
    t_ready_time();
    wrap_up();
  end
endmodule : dac_data_override_regs_tb
